// ===== hdl/ptrig_defines.vh
`ifndef PTRIG_DEFINES_VH
`define PTRIG_DEFINES_VH

// register byte offsets
`define PTRIG_CTRL_OFS      8'h00
`define PTRIG_STATUS_OFS    8'h04
`define PTRIG_IRQ_STAT_OFS  8'h08
`define PTRIG_IRQ_MASK_OFS  8'h0c
`define PTRIG_ERROR_OFS     8'h10
`define PTRIG_LAYOUTS_OFS   8'h14

// control fields
`define PTRIG_CTRL_STATIC   0
`define PTRIG_CTRL_EXTMEM   1
`define PTRIG_CTRL_VARS     2
`define PTRIG_CTRL_RST      32'h0000_0000

// irq status fields
`define PTRIG_IRQ_ORDER_DONE 0
`define PTRIG_IRQ_ERROR      1
`define PTRIG_IRQ_DISCARD    2
`define PTRIG_IRQ_W          3

// error codes
`define PTRIG_ERR_NONE      8'h00
`define PTRIG_ERR_MEASURE   8'h08
`define PTRIG_ERR_RIBBON    8'h0a
`define PTRIG_ERR_STOPBIT   8'h0b
`define PTRIG_ERR_CHECKBIT  8'h0c
`define PTRIG_ERR_DATALOSS  8'h0d

// minimum start pulse width, for reference of the far side
`define PTRIG_START_MIN_MS  50

`endif

// ===== hdl/ptrig_top.v
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ptrig_defines.vh"
// Contract
// RULE1 - dynamic mode starts only on a rising edge of print start
// RULE2 - controller holds each dynamic start pulse at least 50 ms
// RULE3 - static mode starts on high level, continues at once if layout generated
// RULE4 - static level removed: finish current layout, then halt
// RULE5 - start trigger during a print in progress is discarded
// RULE6 - print order output stays high until all layouts printed
// RULE7 - standard memory: next order generated only after previous order ends
// RULE8 - extended memory: next order generated early, ready raised
// RULE9 - extended memory: received data generated after an order starts
// RULE10 - dynamic mode: layout spacing set by trigger interval only
// RULE11 - layouts with variables are regenerated for every layout
// RULE12 - identical layouts are generated once and reused
// RULE13 - a multi-layout order is received from host only once
// RULE14 - next layout data may be received while printing
// RULE15 - serial faults get codes: stop bit 11, check bit 12, data loss 13
// RULE16 - no label during measurement raises error 8
// RULE17 - ribbon out during an order raises error 10
// RULE18 - shorter layout shortens trigger interval in standard mode only
// RULE19 - print start is synchronised before edge or level detection
module ptrig_top #(
    parameter GEN_CYCLES = 16'h0010
) (
    input  wire        clk_in,
    input  wire        reset_in,
    input  wire        clk_en_in,
    input  wire        print_start_in,
    input  wire        data_rx_in,
    input  wire        layout_fed_in,
    input  wire        serial_stop_bit_fault_in,
    input  wire        serial_check_bit_fault_in,
    input  wire        serial_data_loss_fault_in,
    input  wire        no_label_in,
    input  wire        ribbon_out_in,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         print_order_out,
    output reg         ready_out,
    output reg         print_out,
    output reg         head_up_out,
    output reg         irq_out
);

    // sequencer states
    localparam ST_IDLE  = 2'h0;
    localparam ST_PRINT = 2'h1;
    localparam ST_WAIT  = 2'h2;

    // software registers
    reg [31:0] ctrl_q;
    reg [7:0]  layouts_q;
    reg [2:0]  irq_mask_q;
    reg [2:0]  irq_stat_q;
    reg [7:0]  err_q;

    // start input synchroniser and edge memory
    reg        sync1_q;
    reg        sync2_q;
    reg        start_prev_q;

    // order sequencing and layout generation
    reg [1:0]  state_q;
    reg [7:0]  left_q;
    reg        order_q;
    reg        gen_done_q;
    reg        generating_q;
    reg        next_ready_q;
    reg        data_have_q;
    reg        regen_q;
    reg        gen_next_q;
    reg [15:0] gen_cnt_q;

    // bus write holding registers
    reg [7:0]  aw_q;
    reg        aw_have_q;
    reg [31:0] w_q;
    reg        w_have_q;

    // control fields
    wire static_mode = ctrl_q[`PTRIG_CTRL_STATIC];
    wire ext_mem     = ctrl_q[`PTRIG_CTRL_EXTMEM];
    wire has_vars    = ctrl_q[`PTRIG_CTRL_VARS];

    // start detection and bus events
    wire start_edge  = sync2_q & ~start_prev_q;
    wire start_ok    = static_mode ? sync2_q : start_edge;
    wire rd_fire     = s_axi_arvalid & s_axi_arready;
    wire wr_go       = aw_have_q & w_have_q & ~s_axi_bvalid;

    // sequencing events
    wire [2:0] irq_ev;
    wire       gen_fin   = generating_q & (gen_cnt_q == 16'h0001);
    wire       fed       = (state_q == ST_PRINT) & layout_fed_in;
    wire       last_fed  = fed & (left_q == 8'h01);
    wire       new_order = (state_q == ST_IDLE) & start_ok & gen_done_q;

    // error code priority and event flags
    reg [7:0] err_d;
    always @* begin
        err_d = 8'h00;
        if (serial_stop_bit_fault_in)
            err_d = `PTRIG_ERR_STOPBIT; // RULE15
        else if (serial_check_bit_fault_in)
            err_d = `PTRIG_ERR_CHECKBIT; // RULE15
        else if (serial_data_loss_fault_in)
            err_d = `PTRIG_ERR_DATALOSS; // RULE15
        else if (no_label_in)
            err_d = `PTRIG_ERR_MEASURE; // RULE16
        else if (ribbon_out_in && order_q)
            err_d = `PTRIG_ERR_RIBBON; // RULE17
    end

    assign irq_ev[`PTRIG_IRQ_ORDER_DONE] = (state_q == ST_PRINT) & layout_fed_in & (left_q == 8'h01);
    assign irq_ev[`PTRIG_IRQ_ERROR]      = (err_d != 8'h00);
    assign irq_ev[`PTRIG_IRQ_DISCARD]    = start_edge & (state_q == ST_PRINT); // RULE5

    // start synchroniser and edge memory
    always @(posedge clk_in) begin
        if (reset_in) begin
            sync1_q      <= 1'b0;
            sync2_q      <= 1'b0;
            start_prev_q <= 1'b0;
        end else if (clk_en_in) begin
            sync1_q      <= print_start_in; // RULE19
            sync2_q      <= sync1_q; // RULE19
            start_prev_q <= sync2_q; // RULE1
        end
    end

    // next values of generation and sequencing
    reg        data_have_d;
    reg        generating_d;
    reg [15:0] gen_cnt_d;
    reg        gen_done_d;
    reg        next_ready_d;
    reg        regen_d;
    reg        gen_next_d;
    reg [1:0]  state_d;
    reg [7:0]  left_d;
    reg        order_d;

    // layout generation: once per order, again for each layout with variables
    always @* begin
        data_have_d  = data_have_q;
        generating_d = generating_q;
        gen_cnt_d    = gen_cnt_q;
        gen_done_d   = gen_done_q;
        next_ready_d = next_ready_q;
        regen_d      = regen_q;
        gen_next_d   = gen_next_q;
        if (generating_q) begin
            gen_cnt_d = gen_cnt_q - 16'h0001;
            if (gen_fin) begin
                generating_d = 1'b0;
                if (gen_next_q && order_q)
                    next_ready_d = 1'b1; // RULE8
                else
                    gen_done_d = 1'b1;
            end
        end else if (regen_q) begin
            generating_d = 1'b1; // RULE11
            gen_cnt_d    = GEN_CYCLES;
            regen_d      = 1'b0;
            gen_next_d   = 1'b0;
        end else if (data_have_q && !next_ready_q &&
                     ((!order_q && !gen_done_q) || (ext_mem && order_q))) begin
            generating_d = 1'b1; // RULE7 RULE8 RULE9
            gen_cnt_d    = GEN_CYCLES;
            data_have_d  = 1'b0;
            gen_next_d   = order_q;
        end
        // host data may arrive while a layout prints, after the take above
        if (data_rx_in)
            data_have_d = 1'b1; // RULE13 RULE14
        if (fed && has_vars && !last_fed) begin
            gen_done_d = 1'b0; // RULE11
            regen_d    = 1'b1; // RULE11
        end
        // identical layouts keep the generated one until the order ends
        if (last_fed) begin
            gen_done_d   = next_ready_d; // RULE7 RULE12
            next_ready_d = 1'b0;
        end
    end

    // order and print sequencing
    always @* begin
        state_d = state_q;
        left_d  = left_q;
        order_d = order_q;
        case (state_q)
            ST_IDLE: begin
                if (new_order) begin
                    state_d = ST_PRINT; // RULE1 RULE3 RULE10
                    order_d = 1'b1;
                    left_d  = (layouts_q == 8'h00) ? 8'h01 : layouts_q;
                end
            end
            ST_PRINT: begin
                if (layout_fed_in) begin
                    left_d = left_q - 8'h01;
                    if (left_q == 8'h01) begin
                        order_d = 1'b0; // RULE6 RULE7 RULE18
                        state_d = ST_IDLE;
                    end else if (static_mode && sync2_q && gen_done_q && !has_vars) begin
                        state_d = ST_PRINT; // RULE3 RULE12
                    end else begin
                        state_d = ST_WAIT; // RULE4
                    end
                end
            end
            ST_WAIT: begin
                // next layout of the order waits for generation and a start edge, or a high level in static mode
                if (gen_done_q && start_ok)
                    state_d = ST_PRINT; // RULE1 RULE3
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // generation and sequencing registers
    always @(posedge clk_in) begin
        if (reset_in) begin
            state_q      <= ST_IDLE;
            left_q       <= 8'h00;
            order_q      <= 1'b0;
            data_have_q  <= 1'b0;
            generating_q <= 1'b0;
            gen_cnt_q    <= 16'h0000;
            gen_done_q   <= 1'b0;
            next_ready_q <= 1'b0;
            regen_q      <= 1'b0;
            gen_next_q   <= 1'b0;
        end else if (clk_en_in) begin
            state_q      <= state_d;
            left_q       <= left_d;
            order_q      <= order_d;
            data_have_q  <= data_have_d;
            generating_q <= generating_d;
            gen_cnt_q    <= gen_cnt_d;
            gen_done_q   <= gen_done_d;
            next_ready_q <= next_ready_d;
            regen_q      <= regen_d;
            gen_next_q   <= gen_next_d;
        end
    end

    // pin outputs
    always @(posedge clk_in) begin
        if (reset_in) begin
            print_order_out <= 1'b0;
            ready_out       <= 1'b0;
            print_out       <= 1'b0;
            head_up_out     <= 1'b1;
            irq_out         <= 1'b0;
        end else if (clk_en_in) begin
            print_order_out <= order_q; // RULE6
            ready_out       <= (gen_done_q && state_q != ST_PRINT) || next_ready_q; // RULE8
            print_out       <= (state_q == ST_PRINT);
            head_up_out     <= (state_q != ST_PRINT);
            irq_out         <= |(irq_stat_q & irq_mask_q);
        end
    end

    // axi4-lite slave: write path, address and data taken in either order
    always @(posedge clk_in) begin
        if (reset_in) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_q          <= 8'h00;
            w_q           <= 32'h0000_0000;
            ctrl_q        <= `PTRIG_CTRL_RST;
            layouts_q     <= 8'h01;
            irq_mask_q    <= 3'h0;
        end else if (clk_en_in) begin
            s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_q      <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_q      <= s_axi_wdata;
            end
            if (wr_go) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'h0;
                case (aw_q)
                    `PTRIG_CTRL_OFS:     ctrl_q     <= {29'h0, w_q[2:0]};
                    `PTRIG_IRQ_MASK_OFS: irq_mask_q <= w_q[2:0];
                    `PTRIG_LAYOUTS_OFS:  layouts_q  <= w_q[7:0];
                    `PTRIG_STATUS_OFS, `PTRIG_IRQ_STAT_OFS, `PTRIG_ERROR_OFS: s_axi_bresp <= 2'h0;
                    default:             s_axi_bresp <= 2'h2;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi4-lite slave: read path
    always @(posedge clk_in) begin
        if (reset_in) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else if (clk_en_in) begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                case (s_axi_araddr)
                    `PTRIG_CTRL_OFS:     s_axi_rdata <= ctrl_q;
                    `PTRIG_STATUS_OFS:   s_axi_rdata <= {24'h0, left_q[3:0], order_q, gen_done_q, state_q};
                    `PTRIG_IRQ_STAT_OFS: s_axi_rdata <= {29'h0, irq_stat_q};
                    `PTRIG_IRQ_MASK_OFS: s_axi_rdata <= {29'h0, irq_mask_q};
                    `PTRIG_ERROR_OFS:    s_axi_rdata <= {24'h0, err_q};
                    `PTRIG_LAYOUTS_OFS:  s_axi_rdata <= {24'h0, layouts_q};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // last error code, kept until a newer fault replaces it
    always @(posedge clk_in) begin
        if (reset_in) begin
            err_q <= `PTRIG_ERR_NONE;
        end else if (clk_en_in) begin
            if (err_d != 8'h00)
                err_q <= err_d; // RULE15 RULE16 RULE17
        end
    end

    // sticky irq status, cleared by its read; an event in that cycle wins
    always @(posedge clk_in) begin
        if (reset_in) begin
            irq_stat_q <= 3'h0;
        end else if (clk_en_in) begin
            if (rd_fire && s_axi_araddr == `PTRIG_IRQ_STAT_OFS)
                irq_stat_q <= irq_ev;
            else
                irq_stat_q <= irq_stat_q | irq_ev;
        end
    end

endmodule

// ===== verification/ptrig_asserts.sv
`timescale 1ns/1ps
module ptrig_asserts (
    input wire clk_in,
    input wire reset_in,
    input wire print_start_in,
    input wire layout_fed_in,
    input wire s_axi_awvalid,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire print_order_out,
    input wire print_out,
    input wire head_up_out,
    input wire irq_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    // print outputs against their causes, bus answers against requests
    a_reset_idle: assert property ($fell(reset_in) |-> head_up_out && !print_out && !print_order_out && !irq_out)
        else $error("outputs busy after reset");
    a_head_up_print: assert property (head_up_out == !print_out)
        else $error("head and print disagree");
    a_print_in_order: assert property (print_out |-> print_order_out)
        else $error("print outside order");
    a_print_held: assert property (print_out && !layout_fed_in && !$past(layout_fed_in) |=> print_out)
        else $error("print dropped before feed");
    a_order_end_fed: assert property ($fell(print_order_out) |-> $past(layout_fed_in) || $past(layout_fed_in, 2))
        else $error("order ended without feed");
    a_start_first: assert property ($rose(print_out) |-> $past(print_start_in, 2))
        else $error("print without start");
    a_write_answer: assert property ($rose(s_axi_awvalid) |-> ##[2:4] s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property ($rose(s_axi_arvalid) |-> ##[1:3] s_axi_rvalid)
        else $error("read not answered");
    a_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answered twice");
    c_order: cover property ($fell(print_order_out));
    c_irq: cover property ($rose(irq_out));
    c_print: cover property ($rose(print_out));
endmodule

bind ptrig_top ptrig_asserts i_ptrig_asserts (.clk_in, .reset_in, .print_start_in, .layout_fed_in,
    .s_axi_awvalid, .s_axi_bvalid, .s_axi_arvalid, .s_axi_rvalid, .s_axi_rready,
    .print_order_out, .print_out, .head_up_out, .irq_out);

// ===== verification/ptrig_controller.sv
`timescale 1ns/1ps
module ptrig_controller #(
    parameter PULSE_CYCLES = 10
) (
    input  wire clk_in,
    input  wire reset_in,
    input  wire fire_in,
    input  wire level_in,
    output wire print_start_out
);
    reg [7:0] left_q;
    // pulse width scaled down from 50 ms to keep runs short
    always @(posedge clk_in) begin
        if (reset_in)
            left_q <= 8'h00;
        else if (fire_in)
            left_q <= 8'(PULSE_CYCLES);
        else if (left_q != 8'h00)
            left_q <= left_q - 8'h01;
    end
    // static mode holds a level, dynamic mode sends held pulses
    assign print_start_out = level_in | (left_q != 8'h00);
endmodule

// ===== verification/ptrig_top_test.sv
`timescale 1ns/1ps
module ptrig_top_test;
    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        level = 1'b0;
    logic [7:0]  pin = 8'h00;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    wire         start;
    wire         awready, wready, bvalid, arready, rvalid;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire         order, printing, ready, head_up, irq;
    wire [2:0]   outs = {order, printing, ready};
    int          n_errors = 0;
    int          n_checks = 0;
    int          n;
    logic [31:0] d;
    logic [1:0]  r;
    logic [31:0] codes [4] = '{32'h0b, 32'h0c, 32'h0d, 32'h08};

    // 100 ns clock
    always #50 clk_in = ~clk_in;

    ptrig_controller #(.PULSE_CYCLES(10)) i_ptrig_controller (.clk_in(clk_in), .reset_in(reset_in),
        .fire_in(pin[7]), .level_in(level), .print_start_out(start));
    ptrig_top #(.GEN_CYCLES(16'h0002)) i_ptrig_top (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(1'b1),
        .print_start_in(start), .data_rx_in(pin[0]), .layout_fed_in(pin[1]), .serial_stop_bit_fault_in(pin[2]),
        .serial_check_bit_fault_in(pin[3]), .serial_data_loss_fault_in(pin[4]), .no_label_in(pin[5]),
        .ribbon_out_in(pin[6]), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .print_order_out(order), .ready_out(ready),
        .print_out(printing), .head_up_out(head_up), .irq_out(irq));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // ready sampled before an edge is the handshake at that edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [2:0] h;
        h = 3'h0;
        @(posedge clk_in);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!h[0]) begin
            @(negedge clk_in);
            h = {awready, wready, bvalid};
            r = bresp;
            @(posedge clk_in);
            if (h[2]) awvalid <= 1'b0;
            if (h[1]) wvalid <= 1'b0;
            if (h[0]) bready <= 1'b0;
        end
    endtask

    task automatic rd(input logic [7:0] a);
        logic [1:0] h;
        h = 2'h0;
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!h[0]) begin
            @(negedge clk_in);
            h = {arready, rvalid};
            d = rdata;
            r = rresp;
            @(posedge clk_in);
            if (h[1]) arvalid <= 1'b0;
            if (h[0]) rready <= 1'b0;
        end
    endtask

    task automatic pulse(input int k);
        @(posedge clk_in);
        pin[k] <= 1'b1;
        @(posedge clk_in);
        pin[k] <= 1'b0;
    endtask

    task automatic wait_out(input int k, input logic v, input string what);
        @(negedge clk_in);
        repeat (3000) if (outs[k] !== v) @(negedge clk_in);
        check(what, 32'(outs[k]), 32'(v));
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        d = $urandom(32'hc40c);
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(8'h14);
        check("layouts", d, 32'h1);
        rd(8'h40);
        check("unmapped", 32'(r), 32'h2);
        wr(8'h40, 32'h0);
        check("unmapped write", 32'(r), 32'h2);
        // dynamic order of random length, a second start while printing
        wr(8'h0c, 32'h7);
        n = $urandom_range(3, 1);
        wr(8'h00, {29'h0, 1'($urandom_range(1, 0)), 2'b00});
        wr(8'h14, n);
        pulse(0);
        for (int i = 0; i < n; i++) begin
            wait_out(0, 1'b1, "ready");
            pulse(7);
            wait_out(1, 1'b1, "print");
            check("order", 32'(order), 32'h1);
            repeat (12) @(posedge clk_in);
            pulse(7);
            repeat (12) @(posedge clk_in);
            pulse(1);
        end
        wait_out(2, 1'b0, "order end");
        rd(8'h08);
        check("irq status", d, 32'h5);
        // static level: continue, then halt after level drop
        wr(8'h00, 32'h1);
        wr(8'h14, 32'h4);
        pulse(0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in);
            level <= 1'b1;
            wait_out(1, 1'b1, "static print");
            @(posedge clk_in);
            level <= (i % 2 == 0);
            repeat (3) @(posedge clk_in);
            pulse(1);
            repeat (20) @(posedge clk_in);
            if (i == 1) check("halted", 32'(printing), 32'h0);
        end
        wait_out(2, 1'b0, "static end");
        // extended memory: next order generated during print
        wr(8'h00, 32'h2);
        wr(8'h14, 32'h1);
        pulse(0);
        wait_out(0, 1'b1, "ready");
        pulse(7);
        wait_out(1, 1'b1, "print");
        pulse(0);
        repeat (8) @(posedge clk_in);
        check("early ready", 32'({ready, printing, head_up}), 32'h6);
        pulse(6);
        rd(8'h10);
        check("ribbon", d, 32'h0a);
        pulse(1);
        wait_out(2, 1'b0, "order end");
        pulse(7);
        wait_out(1, 1'b1, "next print");
        pulse(1);
        for (int k = 0; k < 4; k++) begin
            pulse(k + 2);
            rd(8'h10);
            check("error code", d, codes[k]);
        end
        // interrupt masked, raised, cleared
        wr(8'h0c, 32'h0);
        repeat (2) @(posedge clk_in);
        check("irq masked", 32'(irq), 32'h0);
        wr(8'h0c, 32'h2);
        repeat (2) @(posedge clk_in);
        check("irq raised", 32'(irq), 32'h1);
        rd(8'h08);
        repeat (2) @(posedge clk_in);
        check("irq cleared", 32'(irq), 32'h0);
        give_verdict;
    end

    // watchdog
    initial begin
        repeat (30000) @(posedge clk_in);
        n_errors++;
        give_verdict;
    end
endmodule
